// ===== inc/mtx_regs.vh
`ifndef MTX_REGS_VH
`define MTX_REGS_VH
// ============================================================
// word offsets (byte address bits 2:1)
`define MTX_OFS_CSR 2'h0
`define MTX_OFS_PARAM 2'h1
`define MTX_OFS_ENA_TX_SERVICE_REQUEST 2'h2
`define MTX_OFS_TX_HOLDING_BUFFER_MODEM 2'h3
// ============================================================
// control_status_word fields
`define MTX_CSR_SRQ 15
`define MTX_CSR_TIE 14
`define MTX_CSR_LINE_HI 10
`define MTX_CSR_LINE_LO 8
`define MTX_CSR_MSE 5
`define MTX_CSR_CLR 4
// ============================================================
// reset values and timing
`define MTX_RST_BYTE 8'h00
`define MTX_CLEAR_CYCLES 5'h10
`define MTX_BIT_CYCLES 12'h823
`define MTX_FRAME_BITS 4'ha
`endif

// ===== logic/mtx_scanner.v
`timescale 1ns/100ps
`include "mtx_regs.vh"
module mtx_scanner (
    clk,
    rst,
    bus_addr,
    bus_wr,
    bus_rd,
    bus_be,
    bus_wdata,
    bus_rdata,
    tx_irq_req,
    txd,
    term_ready,
    carrier_pin,
    ring_pin
);
    input wire clk;
    input wire rst;
    input wire [1:0] bus_addr;
    input wire bus_wr;
    input wire bus_rd;
    input wire [1:0] bus_be;
    input wire [15:0] bus_wdata;
    output reg [15:0] bus_rdata;
    output reg tx_irq_req;
    output wire [7:0] txd;
    output reg [7:0] term_ready;
    input wire [7:0] carrier_pin;
    input wire [7:0] ring_pin;

    // ============================================================
    // helpers
    function wr_hit;
        input [1:0] a;
        input [1:0] ofs;
        input we;
        input be;
        begin
            wr_hit = we && (a == ofs) && be;
        end
    endfunction

    function [3:0] top_line;
        input [7:0] req;
        integer k;
        begin
            top_line = 4'h0;
            for (k = 0; k < 8; k = k + 1) begin
                if (req[k]) begin
                    top_line = {1'b1, k[2:0]};
                end
            end
        end
    endfunction

    function [7:0] settle;
        input [7:0] cur;
        input [7:0] st2;
        input [7:0] st3;
        begin
            settle = (cur & (st2 ^ st3)) | (st2 & ~(st2 ^ st3));
        end
    endfunction

    // ============================================================
    // registers
    reg [7:0] line_enable_reg;
    reg [7:0] line_break_control;
    reg [15:0] param_reg;
    reg tie_reg;
    reg mse_reg;
    reg srq_reg;
    reg [2:0] served_line_number;
    reg clearing_reg;
    reg [4:0] clear_cnt_reg;
    reg [11:0] bit_cnt_reg;
    reg bit_tick;
    reg [7:0] car_s1, car_s2, car_s3, carrier_inputs;
    reg [7:0] ring_s1, ring_s2, ring_s3, ring_inputs;

    wire soft_clr = clearing_reg;
    wire wr_csr_lo = wr_hit(bus_addr, `MTX_OFS_CSR, bus_wr, bus_be[0]);
    wire wr_csr_hi = wr_hit(bus_addr, `MTX_OFS_CSR, bus_wr, bus_be[1]);
    wire wr_ena = wr_hit(bus_addr, `MTX_OFS_ENA_TX_SERVICE_REQUEST, bus_wr, bus_be[0]);
    wire wr_dtr = wr_hit(bus_addr, `MTX_OFS_ENA_TX_SERVICE_REQUEST, bus_wr, bus_be[1]);
    wire wr_tx_holding_buffer = wr_hit(bus_addr, `MTX_OFS_TX_HOLDING_BUFFER_MODEM, bus_wr, bus_be[0]);
    wire wr_brk = wr_hit(bus_addr, `MTX_OFS_TX_HOLDING_BUFFER_MODEM, bus_wr, bus_be[1]);
    wire wr_param = bus_wr && (bus_addr == `MTX_OFS_PARAM);

    // ============================================================
    // control word, parameter store, device clear
    always @(posedge clk) begin
        if (rst) begin
            tie_reg <= 1'b0;
            mse_reg <= 1'b0;
            param_reg <= 16'h0000;
            clearing_reg <= 1'b0;
            clear_cnt_reg <= 5'h00;
        // fixed-length clear; terminal ready left alone
        end else if (soft_clr) begin
            tie_reg <= 1'b0;
            mse_reg <= 1'b0;
            param_reg <= 16'h0000;
            clear_cnt_reg <= clear_cnt_reg - 5'h01;
            if (clear_cnt_reg == 5'h01) begin
                clearing_reg <= 1'b0;
            end
        end else begin
            if (wr_csr_lo) begin
                mse_reg <= bus_wdata[`MTX_CSR_MSE];
                if (bus_wdata[`MTX_CSR_CLR]) begin
                    clearing_reg <= 1'b1;
                    clear_cnt_reg <= `MTX_CLEAR_CYCLES;
                end
            end
            if (wr_csr_hi) begin
                tie_reg <= bus_wdata[`MTX_CSR_TIE];
            end
            if (wr_param) begin
                param_reg <= bus_wdata;
            end
        end
    end

    // ============================================================
    // enables, break, terminal ready
    always @(posedge clk) begin
        if (rst || soft_clr) begin
            line_enable_reg <= `MTX_RST_BYTE;
            line_break_control <= `MTX_RST_BYTE;
        end else begin
            if (wr_ena) begin
                line_enable_reg <= bus_wdata[7:0];
            end
            if (wr_brk) begin
                line_break_control <= bus_wdata[15:8];
            end
        end
    end

    // terminal ready survives the soft clear
    always @(posedge clk) begin
        if (rst) begin
            term_ready <= `MTX_RST_BYTE;
        end else if (wr_dtr) begin
            term_ready <= bus_wdata[15:8];
        end
    end

    // ============================================================
    // modem inputs, own sampling path only
    always @(posedge clk) begin
        if (rst) begin
            car_s1 <= 8'h00;
            car_s2 <= 8'h00;
            car_s3 <= 8'h00;
            carrier_inputs <= 8'h00;
            ring_s1 <= 8'h00;
            ring_s2 <= 8'h00;
            ring_s3 <= 8'h00;
            ring_inputs <= 8'h00;
        end else begin
            car_s1 <= carrier_pin;
            car_s2 <= car_s1;
            car_s3 <= car_s2;
            ring_s1 <= ring_pin;
            ring_s2 <= ring_s1;
            ring_s3 <= ring_s2;
            // a level change counts once stages two and three agree
            carrier_inputs <= settle(carrier_inputs, car_s2, car_s3);
            ring_inputs <= settle(ring_inputs, ring_s2, ring_s3);
        end
    end

    // ============================================================
    // bit rate enable
    // one enable pulse shared by every line's shifter
    always @(posedge clk) begin
        if (rst || soft_clr) begin
            bit_cnt_reg <= 12'h000;
            bit_tick <= 1'b0;
        end else if (bit_cnt_reg == `MTX_BIT_CYCLES - 12'h001) begin
            bit_cnt_reg <= 12'h000;
            bit_tick <= 1'b1;
        end else begin
            bit_cnt_reg <= bit_cnt_reg + 12'h001;
            bit_tick <= 1'b0;
        end
    end

    // ============================================================
    // per-line double buffered transmitters
    wire [7:0] hold_full;
    wire [7:0] load_line;
    wire [7:0] tx_line_bit;

    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : line
            reg [7:0] tx_holding_buffer;
            reg full_reg;
            reg [8:0] shift_reg;
            reg [3:0] bits_left_reg;
            reg line_bit_reg;
            assign hold_full[g] = full_reg;
            assign tx_line_bit[g] = line_bit_reg;
            assign load_line[g] = wr_tx_holding_buffer && srq_reg &&
                                  (served_line_number == g);
            // holding register drains only into an idle shifter
            always @(posedge clk) begin
                if (rst || soft_clr) begin
                    full_reg <= 1'b0;
                    tx_holding_buffer <= 8'h00;
                    shift_reg <= 9'h1ff;
                    bits_left_reg <= 4'h0;
                    line_bit_reg <= 1'b1;
                end else begin
                    if (load_line[g]) begin
                        tx_holding_buffer <= bus_wdata[7:0];
                        full_reg <= 1'b1;
                    end else if (full_reg && bits_left_reg == 4'h0) begin
                        shift_reg <= {tx_holding_buffer, 1'b0};
                        bits_left_reg <= `MTX_FRAME_BITS;
                        full_reg <= 1'b0;
                    end
                    if (bit_tick && bits_left_reg != 4'h0) begin
                        line_bit_reg <= shift_reg[0];
                        shift_reg <= {1'b1, shift_reg[8:1]};
                        bits_left_reg <= bits_left_reg - 4'h1;
                    end else if (bit_tick) begin
                        line_bit_reg <= 1'b1;
                    end
                end
            end
        end
    endgenerate

    reg [7:0] txd_reg;
    assign txd = txd_reg;
    always @(posedge clk) begin
        if (rst) begin
            txd_reg <= 8'hff;
        end else begin
            txd_reg <= tx_line_bit & ~line_break_control;
        end
    end

    // ============================================================
    // scanner
    wire [7:0] need_service = line_enable_reg & ~hold_full;
    wire [3:0] pick = top_line(need_service);

    always @(posedge clk) begin
        if (rst || soft_clr) begin
            srq_reg <= 1'b0;
            served_line_number <= 3'h0;
        // ready stands until its line is loaded or disabled
        end else if (srq_reg) begin
            if (load_line[served_line_number] ||
                !line_enable_reg[served_line_number]) begin
                srq_reg <= 1'b0;
            end
        end else if (mse_reg && pick[3]) begin
            srq_reg <= 1'b1;
            served_line_number <= pick[2:0];
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            tx_irq_req <= 1'b0;
        end else begin
            tx_irq_req <= tie_reg && srq_reg && !soft_clr;
        end
    end

    // ============================================================
    // read path
    // read data registered; it stands until the next read
    always @(posedge clk) begin
        if (rst) begin
            bus_rdata <= 16'h0000;
        end else if (bus_rd) begin
            case (bus_addr)
                `MTX_OFS_CSR: begin
                    bus_rdata <= {srq_reg, tie_reg, 3'h0, served_line_number,
                                  2'h0, mse_reg, clearing_reg, 4'h0};
                end
                `MTX_OFS_PARAM: begin
                    bus_rdata <= param_reg;
                end
                `MTX_OFS_ENA_TX_SERVICE_REQUEST: begin
                    bus_rdata <= {term_ready, line_enable_reg};
                end
                `MTX_OFS_TX_HOLDING_BUFFER_MODEM: begin
                    bus_rdata <= {carrier_inputs, ring_inputs};
                end
                default: begin
                    bus_rdata <= 16'h0000;
                end
            endcase
        end
    end
endmodule

// ===== tb/mtx_scanner_asserts.sv
`timescale 1ns/100ps
module mtx_scanner_asserts (
    input wire clk,
    input wire rst,
    input wire [1:0] bus_addr,
    input wire bus_wr,
    input wire bus_rd,
    input wire [1:0] bus_be,
    input wire [15:0] bus_wdata,
    input wire [15:0] bus_rdata,
    input wire tx_irq_req,
    input wire [7:0] txd,
    input wire [7:0] term_ready,
    input wire [7:0] carrier_pin,
    input wire [7:0] ring_pin
);
    // ==========
    // clear tracking
    reg [4:0] cnt_reg;
    reg [7:0] brk_reg;
    reg quiet_reg;
    wire idle = cnt_reg == 5'h00;
    wire clr_go = bus_wr && idle && bus_addr == 2'h0 && bus_be[0] && bus_wdata[4];
    wire ena_wr = bus_addr == 2'h2 && bus_be[0] && bus_wdata[7:0] != 8'h00;
    wire brk_wr = bus_addr == 2'h3 && bus_be[1];
    always @(posedge clk) begin
        if (rst || clr_go) begin
            cnt_reg <= rst ? 5'h00 : 5'h10;
            brk_reg <= 8'h00;
            quiet_reg <= 1'b1;
        end else begin
            if (!idle)
                cnt_reg <= cnt_reg - 5'h01;
            if (bus_wr && idle && brk_wr)
                brk_reg <= bus_wdata[15:8];
            if (bus_wr && idle && (ena_wr || (brk_wr && bus_wdata[15:8] != 8'h00)))
                quiet_reg <= 1'b0;
        end
    end
    // ==========
    // properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_reset_outs: assert property (disable iff (1'b0)
        rst |=> txd == 8'hff && term_ready == 8'h00 && !tx_irq_req) else $error("reset state");
    a_dtr_write: assert property (
        bus_wr && idle && bus_addr == 2'h2 && bus_be[1] |=> term_ready == $past(bus_wdata[15:8]))
        else $error("terminal ready write");
    a_dtr_hold: assert property (
        !(bus_wr && bus_addr == 2'h2 && bus_be[1]) |=> $stable(term_ready)) else $error("dtr moved");
    a_clr_busy: assert property (
        bus_rd && bus_addr == 2'h0 && !idle |=> bus_rdata[4])
        else $error("clear bit low early");
    a_clr_done: assert property (
        bus_rd && bus_addr == 2'h0 && idle && !bus_wr |=> !bus_rdata[4]) else $error("clear stuck");
    a_break_low: assert property (
        (txd & brk_reg & $past(brk_reg, 2)) == 8'h00) else $error("break not low");
    a_quiet_idle: assert property (
        quiet_reg && cnt_reg < 5'h0f |-> txd == 8'hff) else $error("idle not mark");
    a_no_modem_irq: assert property (
        quiet_reg && cnt_reg < 5'h0f |-> !tx_irq_req) else $error("stray irq");
endmodule
bind mtx_scanner mtx_scanner_asserts u_chk (.clk(clk), .rst(rst), .bus_addr(bus_addr),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_be(bus_be), .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata), .tx_irq_req(tx_irq_req), .txd(txd), .term_ready(term_ready),
    .carrier_pin(carrier_pin), .ring_pin(ring_pin));

// ===== tb/mtx_modem_model.sv
`timescale 1ns/100ps
module mtx_modem_model (
    input wire clk,
    input wire [7:0] term_ready,
    input wire [7:0] ring_cmd,
    output reg [7:0] carrier_pin,
    output reg [7:0] ring_pin
);
    reg [7:0] dly_reg = 8'h00;
    // carrier answers terminal ready two cycles later
    always @(posedge clk) begin
        dly_reg <= term_ready;
        carrier_pin <= dly_reg;
        ring_pin <= ring_cmd;
    end
endmodule

// ===== tb/mtx_scanner_tb.sv
`timescale 1ns/100ps
`define CHK(a, b) begin check_count = check_count + 1; if ((a) !== (b)) begin \
n_mismatch = n_mismatch + 1; $display("ERROR %0t: got %h exp %h", $time, a, b); end end
module mtx_scanner_tb;
    reg clk, rst, bus_wr, bus_rd;
    reg [1:0] bus_addr, bus_be;
    reg [15:0] bus_wdata, rv, seed;
    reg [7:0] ring_cmd, dtr, mask;
    wire [15:0] bus_rdata;
    wire tx_irq_req;
    wire [7:0] txd, term_ready, carrier_pin, ring_pin;
    integer n_mismatch = 0, check_count = 0, cyc = 0, i, k;
    mtx_scanner dut (.clk(clk), .rst(rst), .bus_addr(bus_addr), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_be(bus_be), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
        .tx_irq_req(tx_irq_req), .txd(txd), .term_ready(term_ready),
        .carrier_pin(carrier_pin), .ring_pin(ring_pin));
    mtx_modem_model u_modem (.clk(clk), .term_ready(term_ready), .ring_cmd(ring_cmd),
        .carrier_pin(carrier_pin), .ring_pin(ring_pin));
    function [15:0] lfsr(input [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function [2:0] top_line(input [7:0] m);
        integer j;
        begin
            top_line = 3'h0;
            for (j = 0; j < 8; j = j + 1)
                if (m[j]) top_line = j[2:0];
        end
    endfunction
    task wr(input [1:0] a, input [1:0] b, input [15:0] d);
        begin
            @(posedge clk);
            bus_addr <= a;
            bus_be <= b;
            bus_wdata <= d;
            bus_wr <= 1'b1;
            @(posedge clk);
            bus_wr <= 1'b0;
            #1;
        end
    endtask
    task rd(input [1:0] a);
        begin
            @(posedge clk);
            bus_addr <= a;
            bus_rd <= 1'b1;
            @(posedge clk);
            bus_rd <= 1'b0;
            @(posedge clk);
            #1 rv = bus_rdata;
        end
    endtask
    task wait_rdy;
        begin
            k = 0;
            rd(2'h0);
            while (rv[15] !== 1'b1 && k < 9000) begin
                rd(2'h0);
                k = k + 1;
            end
        end
    endtask
    task end_sim;
        begin
            $display("checks %0d mismatches %0d", check_count, n_mismatch);
            if (n_mismatch == 0 && check_count > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 95000) begin
            n_mismatch = n_mismatch + 1;
            end_sim;
        end
    end
    initial begin
        {rst, bus_wr, bus_rd, bus_addr, bus_be, bus_wdata} = {3'b100, 20'h00000};
        seed = 16'hdbc1;
        ring_cmd = 8'h00;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        #1;
        `CHK({txd, term_ready}, 16'hff00)
        // ==========
        // modem registers, byte and word lanes
        for (i = 0; i < 4; i = i + 1) begin
            seed = lfsr(seed);
            ring_cmd <= seed[7:0];
            dtr = (i == 0) ? 8'hff : seed[15:8];
            wr(2'h2, 2'b10, {~dtr, 8'h00});
            wr(2'h2, 2'b11, {dtr, 8'h00});
            `CHK(term_ready, dtr)
            wr(2'h2, 2'b01, {~dtr, 8'h00});
            repeat (8) @(posedge clk);
            rd(2'h3);
            `CHK(rv, {dtr, ring_cmd})
            rd(2'h2);
            `CHK(rv, {dtr, 8'h00})
        end
        // ==========
        // soft clear keeps terminal ready
        wr(2'h0, 2'b01, 16'h0010);
        rd(2'h0);
        `CHK(rv[4], 1'b1)
        wait_rdy_clear: for (k = 0; k < 20 && rv[4] !== 1'b0; k = k + 1)
            rd(2'h0);
        `CHK(k < 8, 1'b1)
        `CHK(term_ready, dtr)
        // ==========
        // priority across enabled lines
        seed = lfsr(seed);
        mask = seed[7:0] | 8'h81;
        wr(2'h2, 2'b01, {8'h00, mask});
        wr(2'h0, 2'b01, 16'h0020);
        while (mask != 8'h00) begin
            wait_rdy;
            `CHK({rv[15], rv[10:8]}, {1'b1, top_line(mask)})
            mask[top_line(mask)] = 1'b0;
            wr(2'h2, 2'b01, {8'h00, mask});
        end
        rd(2'h0);
        `CHK(rv[15], 1'b0)
        // ==========
        // line 2: data, zero, break, zero, data, then stop
        wr(2'h2, 2'b01, 16'h0004);
        wr(2'h0, 2'b11, 16'h4020);
        wait_rdy;
        `CHK({rv[15], rv[10:8]}, 4'ha)
        `CHK(tx_irq_req, 1'b1)
        wr(2'h3, 2'b01, {8'h00, seed[15:8]});
        wait_rdy;
        `CHK(k < 3, 1'b1)
        `CHK({rv[15], rv[10:8]}, 4'ha)
        wr(2'h3, 2'b01, 16'h0000);
        rd(2'h0);
        `CHK(rv[15], 1'b0)
        wait_rdy;
        // break only once two characters ahead have left the holding side
        wr(2'h3, 2'b10, 16'h0400);
        wr(2'h3, 2'b01, 16'h0000);
        wait_rdy;
        `CHK({rv[15], rv[10:8], txd[2]}, 5'h14)
        wr(2'h3, 2'b10, 16'h0000);
        seed = lfsr(seed);
        wr(2'h3, 2'b01, {8'h00, seed[7:0]});
        wait_rdy;
        `CHK({rv[15], rv[10:8]}, 4'ha)
        wr(2'h2, 2'b01, 16'h0000);
        rd(2'h0);
        `CHK(rv[15], 1'b0)
        repeat (21000) @(posedge clk);
        #1;
        `CHK(txd, 8'hff)
        end_sim;
    end
endmodule
